// file: src/rail_c_regs.svh
// Register offsets, field positions, fixed values and constants
`ifndef RAIL_C_REGS_SVH
`define RAIL_C_REGS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_TRANSIENT_ZERO_DETECT 8'h35
`define OFS_RESERVED_FIXED_A      8'h36
`define OFS_RAMP_THRESHOLD        8'h37
`define OFS_ON_TIME_EXTENSION     8'h38
`define OFS_RAMP_UP_COMP          8'h39
`define OFS_QUICK_RESPONSE_WIDTH  8'h3a
`define OFS_OPTION_FLAGS          8'h3b
`define OFS_RESERVED_ONE          8'h3c
`define OFS_RESERVED_TWO          8'h3d
`define OFS_OFFSET_FIRST          8'h3e
`define OFS_OFFSET_THIRD          8'h40
`define OFS_ID_LOW                8'h41
`define OFS_ID_HIGH               8'h42
`define OFS_CHECKSUM              8'h43
`define STORED_REGS               12

// ----------------------------------------------------------------
// Writable masks and fixed (reserved) values
// ----------------------------------------------------------------
`define MASK_ALL                  8'hff
`define MASK_NONE                 8'h00
`define FIXED_RESERVED_A          8'h71
`define MASK_RAMP_THRESHOLD       8'h70
`define FIXED_RAMP_THRESHOLD      8'h02
`define MASK_ON_TIME_EXTENSION    8'h1f
`define MASK_RAMP_UP_COMP         8'h37
`define MASK_QUICK_RESPONSE       8'h03
`define FIXED_QUICK_RESPONSE      8'h20
`define MASK_OPTION_FLAGS         8'hb0
`define MASK_AMP_GAIN             8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define F_RATIO                   7:6
`define F_ZERO_LEVEL              5:0
`define F_RAMP_LEVEL              6:4
`define B_STRETCH_EN              4
`define F_RAISE_LEVEL             3:2
`define F_STRETCH_SEL             1:0
`define F_COMP_RANGE              5:4
`define F_COMP_LEVEL              2:0
`define F_QR_WIDTH                1:0
`define B_FLAT_LOADLINE           7
`define B_SOFT_START_OC           5
`define B_AMP_GAIN                4

// ----------------------------------------------------------------
// Checksum and telemetry
// ----------------------------------------------------------------
`define CRC_POLY                  8'h07
`define CRC_INIT                  8'h00
`define TELEMETRY_MAX             10'h3ff
`define DEFAULT_DEVICE_ADDR       7'h20
`define DEFAULT_CONFIG_ID         16'h5a5a

`endif

// file: src/rail_c_pkg.sv
// Types shared by the rail C register bank
package rail_c_pkg;

  typedef enum logic [6:0] {
    TGT_IDLE     = 7'b0000001,
    TGT_ADDR     = 7'b0000010,
    TGT_ACK      = 7'b0000100,
    TGT_WRITE    = 7'b0001000,
    TGT_READ     = 7'b0010000,
    TGT_READ_ACK = 7'b0100000,
    TGT_IGNORE   = 7'b1000000
  } target_state_e;

  typedef enum logic [1:0] {
    CRC_IDLE = 2'b01,
    CRC_RUN  = 2'b10
  } crc_state_e;

endpackage

// file: src/crc_if.sv
// Request and result signals between the bank and its checksum engine
`timescale 1ns/1ps
interface crc_if #(
  parameter int BYTES = 17
);
  logic               start;
  logic [BYTES*8-1:0] data;
  logic               busy;
  logic [7:0]         result;

  modport requester (output start, output data, input busy, input result);
  modport engine    (input start, input data, output busy, output result);
endinterface

// file: src/crc8_engine.sv
// Byte-serial CRC-8 over a fixed group of configuration bytes
`timescale 1ns/1ps
module crc8_engine
  import rail_c_pkg::*;
#(
  parameter int BYTES = 17
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Request side
  crc_if.engine     crc
);
`include "rail_c_regs.svh"

  localparam int IW = $clog2(BYTES + 1);

  crc_state_e         state;
  crc_state_e         next_state;
  logic [IW-1:0]      idx;
  logic [IW-1:0]      next_idx;
  logic [7:0]         acc;
  logic [7:0]         next_acc;
  logic [7:0]         result;
  logic [7:0]         next_result;
  logic [BYTES*8-1:0] snap;
  logic [BYTES*8-1:0] next_snap;

  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int b = 0; b < 8; b++) begin
      r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  always_comb begin
    next_state  = state;
    next_idx    = idx;
    next_acc    = acc;
    next_result = result;
    next_snap   = snap;
    case (state)
      CRC_IDLE: begin
        if (crc.start) begin
          next_state = CRC_RUN;
          next_idx   = '0;
          next_acc   = `CRC_INIT;
          next_snap  = crc.data;
        end
      end
      CRC_RUN: begin
        // Lowest byte first; result replaced only when the walk ends
        next_acc  = crc_byte(acc, snap[7:0]);
        next_snap = snap >> 8;
        next_idx  = idx + 1'b1;
        if (idx == IW'(BYTES - 1)) begin
          next_result = crc_byte(acc, snap[7:0]);
          next_state  = CRC_IDLE;
        end
      end
      default: next_state = CRC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= CRC_IDLE;
      idx    <= '0;
      acc    <= `CRC_INIT;
      result <= `CRC_INIT;
      snap   <= '0;
    end else begin
      state  <= next_state;
      idx    <= next_idx;
      acc    <= next_acc;
      result <= next_result;
      snap   <= next_snap;
    end
  end

  assign crc.busy   = (state == CRC_RUN);
  assign crc.result = result;

endmodule // crc8_engine

// file: src/rail_c_tuning_and_telemetry_regs.sv
// Rail C tuning and telemetry register bank on a two-wire target port
`timescale 1ns/1ps
module rail_c_tuning_and_telemetry_regs
  import rail_c_pkg::*;
#(
  parameter logic [6:0]  DEVICE_ADDR  = `DEFAULT_DEVICE_ADDR,
  // Arbitrary neutral identifier value
  parameter logic [15:0] CONFIG_ID    = `DEFAULT_CONFIG_ID,
  parameter int          GROUP_BYTES  = 16,
  parameter int          ADC_WIDTH    = 10
) (
  // Clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   rst_n_i,
  // Two-wire configuration port
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  output logic                        sda_o,
  output logic                        sda_oe_o,
  // System status
  input  wire logic                   rail_running_i,
  input  wire logic                   nvm_restore_i,
  input  wire logic [GROUP_BYTES*8-1:0] group_one_i,
  // Current telemetry
  input  wire logic [3*ADC_WIDTH-1:0] adc_current_i,
  output logic      [3*ADC_WIDTH-1:0] current_report_o,
  // Rail C settings
  output logic [1:0]                  transient_target_ratio_o,
  output logic [5:0]                  zero_current_level_o,
  output logic [2:0]                  adaptive_ramp_level_o,
  output logic                        on_time_stretch_enable_o,
  output logic [1:0]                  on_time_raise_level_o,
  output logic [1:0]                  on_time_stretch_select_o,
  output logic [1:0]                  ramp_up_compensation_range_o,
  output logic [2:0]                  ramp_up_compensation_level_o,
  output logic [1:0]                  quick_response_width_o,
  output logic                        flat_loadline_enable_o,
  output logic                        soft_start_overcurrent_enable_o,
  output logic                        amplifier_gain_select_o,
  output logic [7:0]                  fixed_group_checksum_o
);
`include "rail_c_regs.svh"

  localparam int NREG = `STORED_REGS;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  target_state_e    state;
  target_state_e    next_state;
  logic             scl_q;
  logic             sda_q;
  logic [7:0]       shift;
  logic [7:0]       next_shift;
  logic [3:0]       bits;
  logic [3:0]       next_bits;
  logic [7:0]       ptr;
  logic [7:0]       next_ptr;
  logic             ptr_set;
  logic             next_ptr_set;
  logic             rd_mode;
  logic             next_rd_mode;
  logic             drive_low;
  logic             next_drive_low;
  logic [7:0]       rf [NREG];
  logic [7:0]       next_rf [NREG];
  logic             power_on;
  logic             next_power_on;

  logic             scl_rise;
  logic             scl_fall;
  logic             start_seen;
  logic             stop_seen;

  crc_if #(.BYTES(GROUP_BYTES + 1)) crc ();

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  function automatic logic [7:0] write_mask(input logic [7:0] a,
                                            input logic       lock);
    logic [7:0] m;
    m = `MASK_NONE;
    if (a == `OFS_TRANSIENT_ZERO_DETECT) begin
      m = `MASK_ALL;
    end else if (a == `OFS_RAMP_THRESHOLD) begin
      m = `MASK_RAMP_THRESHOLD;
    end else if (a == `OFS_ON_TIME_EXTENSION) begin
      m = `MASK_ON_TIME_EXTENSION;
    end else if (a == `OFS_RAMP_UP_COMP) begin
      m = `MASK_RAMP_UP_COMP;
    end else if (a == `OFS_QUICK_RESPONSE_WIDTH) begin
      m = `MASK_QUICK_RESPONSE;
    end else if (a == `OFS_OPTION_FLAGS) begin
      m = lock ? (`MASK_OPTION_FLAGS & ~`MASK_AMP_GAIN)
               : `MASK_OPTION_FLAGS;
    end else if (a >= `OFS_OFFSET_FIRST && a <= `OFS_OFFSET_THIRD) begin
      m = `MASK_ALL;
    end
    return m;
  endfunction

  function automatic logic [7:0] read_value(input logic [7:0] a,
                                            input logic [7:0] stored,
                                            input logic [7:0] sum);
    logic [7:0] v;
    v = 8'h00;
    if (a >= `OFS_TRANSIENT_ZERO_DETECT && a <= `OFS_OFFSET_THIRD) begin
      v = stored;
    end else if (a == `OFS_ID_LOW) begin
      v = CONFIG_ID[7:0];
    end else if (a == `OFS_ID_HIGH) begin
      v = CONFIG_ID[15:8];
    end else if (a == `OFS_CHECKSUM) begin
      v = sum;
    end
    return v;
  endfunction

  function automatic logic [3:0] reg_index(input logic [7:0] a);
    logic [7:0] d;
    d = a - `OFS_TRANSIENT_ZERO_DETECT;
    return d[3:0];
  endfunction

  // ----------------------------------------------------------------
  // Target port and register file
  // ----------------------------------------------------------------
  assign scl_rise   = scl_i & ~scl_q;
  assign scl_fall   = ~scl_i & scl_q;
  assign start_seen = scl_i & scl_q & sda_q & ~sda_i;
  assign stop_seen  = scl_i & scl_q & ~sda_q & sda_i;

  always_comb begin
    logic [7:0] m;
    logic [3:0] ix;
    m              = 8'h00;
    ix             = 4'h0;
    next_state     = state;
    next_shift     = shift;
    next_bits      = bits;
    next_ptr       = ptr;
    next_ptr_set   = ptr_set;
    next_rd_mode   = rd_mode;
    next_drive_low = drive_low;
    next_rf        = rf;
    if (start_seen) begin
      next_state     = TGT_ADDR;
      next_bits      = 4'h0;
      next_ptr_set   = 1'b0;
      next_drive_low = 1'b0;
    end else if (stop_seen) begin
      next_state     = TGT_IDLE;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        TGT_ADDR, TGT_WRITE: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_i};
            next_bits  = bits + 4'h1;
          end else if (scl_fall && bits == 4'h8) begin
            next_bits = 4'h0;
            if (state == TGT_ADDR) begin
              if (shift[7:1] == DEVICE_ADDR) begin
                next_rd_mode   = shift[0];
                next_drive_low = 1'b1;
                next_state     = TGT_ACK;
              end else begin
                next_state = TGT_IGNORE;
              end
            end else begin
              next_drive_low = 1'b1;
              next_state     = TGT_ACK;
              next_rd_mode   = 1'b0;
              if (!ptr_set) begin
                next_ptr     = shift;
                next_ptr_set = 1'b1;
              end else begin
                m  = write_mask(ptr, rail_running_i);
                ix = reg_index(ptr);
                if (m != `MASK_NONE) begin
                  next_rf[ix] = (rf[ix] & ~m) | (shift & m);
                end
                next_ptr = ptr + 8'h01;
              end
            end
          end
        end
        TGT_ACK: begin
          if (scl_fall) begin
            if (rd_mode) begin
              ix             = reg_index(ptr);
              next_shift     = read_value(ptr, rf[ix], crc.result);
              next_drive_low = ~next_shift[7];
              next_bits      = 4'h0;
              next_state     = TGT_READ;
            end else begin
              next_drive_low = 1'b0;
              next_state     = TGT_WRITE;
            end
          end
        end
        TGT_READ: begin
          if (scl_rise) begin
            next_bits = bits + 4'h1;
          end else if (scl_fall) begin
            if (bits == 4'h8) begin
              next_drive_low = 1'b0;
              next_ptr       = ptr + 8'h01;
              next_state     = TGT_READ_ACK;
            end else begin
              next_shift     = {shift[6:0], 1'b0};
              next_drive_low = ~shift[6];
            end
          end
        end
        TGT_READ_ACK: begin
          // Host acknowledge keeps the burst going, otherwise release
          if (scl_rise) begin
            next_state = sda_i ? TGT_IGNORE : TGT_ACK;
          end
        end
        default: begin
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= TGT_IDLE;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      shift     <= 8'h00;
      bits      <= 4'h0;
      ptr       <= 8'h00;
      ptr_set   <= 1'b0;
      rd_mode   <= 1'b0;
      drive_low <= 1'b0;
      for (int i = 0; i < NREG; i++) begin
        rf[i] <= 8'h00;
      end
      rf[1] <= `FIXED_RESERVED_A;
      rf[2] <= `FIXED_RAMP_THRESHOLD;
      rf[5] <= `FIXED_QUICK_RESPONSE;
    end else begin
      state     <= next_state;
      scl_q     <= scl_i;
      sda_q     <= sda_i;
      shift     <= next_shift;
      bits      <= next_bits;
      ptr       <= next_ptr;
      ptr_set   <= next_ptr_set;
      rd_mode   <= next_rd_mode;
      drive_low <= next_drive_low;
      rf        <= next_rf;
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = drive_low;

  // ----------------------------------------------------------------
  // Checksum refresh
  // ----------------------------------------------------------------
  always_comb begin
    next_power_on = power_on & crc.busy;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_on <= 1'b1;
    end else begin
      power_on <= next_power_on;
    end
  end

  // The gain bit is the only fixed-group setting held here
  assign crc.start = (power_on | nvm_restore_i) & ~crc.busy;
  assign crc.data  = {rf[6] & `MASK_AMP_GAIN, group_one_i};

  crc8_engine #(
    .BYTES (GROUP_BYTES + 1)
  ) u_crc (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .crc     (crc.engine)
  );

  assign fixed_group_checksum_o = crc.result;

  // ----------------------------------------------------------------
  // Field outputs
  // ----------------------------------------------------------------
  assign transient_target_ratio_o        = rf[0][`F_RATIO];
  assign zero_current_level_o            = rf[0][`F_ZERO_LEVEL];
  assign adaptive_ramp_level_o           = rf[2][`F_RAMP_LEVEL];
  assign on_time_stretch_enable_o        = rf[3][`B_STRETCH_EN];
  assign on_time_stretch_select_o        = rf[3][`F_STRETCH_SEL];
  assign on_time_raise_level_o           = rf[3][`F_RAISE_LEVEL];
  assign ramp_up_compensation_range_o    = rf[4][`F_COMP_RANGE];
  assign ramp_up_compensation_level_o    = rf[4][`F_COMP_LEVEL];
  assign quick_response_width_o          = rf[5][`F_QR_WIDTH];
  assign flat_loadline_enable_o          = rf[6][`B_FLAT_LOADLINE];
  assign soft_start_overcurrent_enable_o = rf[6][`B_SOFT_START_OC];
  assign amplifier_gain_select_o         = rf[6][`B_AMP_GAIN];

  // ----------------------------------------------------------------
  // Current telemetry
  // ----------------------------------------------------------------
  function automatic logic [ADC_WIDTH-1:0] offset_code(
      input logic [ADC_WIDTH-1:0] adc, input logic [7:0] ofs);
    logic signed [ADC_WIDTH+1:0] d;
    d = $signed({2'b00, adc}) - $signed({{(ADC_WIDTH-6){ofs[7]}}, ofs});
    if (d < 0) begin
      return '0;
    end else if (d > $signed({2'b00, `TELEMETRY_MAX})) begin
      return `TELEMETRY_MAX;
    end
    return d[ADC_WIDTH-1:0];
  endfunction

  for (genvar g = 0; g < 3; g++) begin : g_rail
    logic [ADC_WIDTH-1:0] report;
    logic [ADC_WIDTH-1:0] next_report;
    always_comb begin
      next_report = offset_code(adc_current_i[g*ADC_WIDTH +: ADC_WIDTH],
                                rf[9+g]);
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        report <= '0;
      end else begin
        report <= next_report;
      end
    end
    assign current_report_o[g*ADC_WIDTH +: ADC_WIDTH] = report;
  end

endmodule // rail_c_tuning_and_telemetry_regs

// file: verif/rail_c_regs_monitor.sv
// Port assertions for the rail C register bank
`timescale 1ns/1ps
module rail_c_regs_monitor #(
  parameter int ADC_WIDTH = 10
) (
  // Watched ports
  input wire logic                   clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   scl_i,
  input wire logic                   sda_o,
  input wire logic                   sda_oe_o,
  input wire logic                   rail_running_i,
  input wire logic                   nvm_restore_i,
  input wire logic [3*ADC_WIDTH-1:0] adc_current_i,
  input wire logic [3*ADC_WIDTH-1:0] current_report_o,
  input wire logic [1:0]             transient_target_ratio_o,
  input wire logic [5:0]             zero_current_level_o,
  input wire logic                   flat_loadline_enable_o,
  input wire logic                   amplifier_gain_select_o,
  input wire logic [7:0]             fixed_group_checksum_o
);
  // ----------------------------------------------------------------
  // Cycles since the last checksum start
  // ----------------------------------------------------------------
  logic [7:0] since_start;
  logic [7:0] next_since_start;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  always_comb begin
    next_since_start = since_start;
    if (nvm_restore_i) begin
      next_since_start = 8'h00;
    end else if (since_start != 8'hff) begin
      next_since_start = since_start + 8'h01;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_start <= 8'h00;
    end else begin
      since_start <= next_since_start;
    end
  end
  sequence scl_fell_s;
    !$past(scl_i) && $past(scl_i, 2);
  endsequence
  a_sda_value_low: assert property (sda_o == 1'b0)
    else $error("data value not low");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i) && !scl_i)
    else $error("data changed with clock high");
  a_ratio_after_ack: assert property ($changed(transient_target_ratio_o) |-> scl_fell_s)
    else $error("ratio changed outside a write");
  a_zero_after_ack: assert property ($changed(zero_current_level_o) |-> $past(scl_i, 2) && !$past(scl_i))
    else $error("zero level changed outside a write");
  a_flat_after_ack: assert property ($changed(flat_loadline_enable_o) |-> scl_fell_s)
    else $error("load-line enable changed outside a write");
  a_gain_locked: assert property (rail_running_i && $past(rail_running_i) |-> $stable(amplifier_gain_select_o))
    else $error("gain changed while running");
  a_report_quiet: assert property (($stable(adc_current_i) && $stable(scl_i)) [*3] ##0 (since_start > 8'h02) |-> $stable(current_report_o))
    else $error("report changed without cause");
  a_checksum_window: assert property ($changed(fixed_group_checksum_o) |-> since_start inside {[8'h0f:8'h14]})
    else $error("checksum changed outside a refresh");
  cover property ($rose(sda_oe_o));
  cover property ($changed(fixed_group_checksum_o));
  cover property (rail_running_i && $changed(flat_loadline_enable_o));
endmodule // rail_c_regs_monitor
bind rail_c_tuning_and_telemetry_regs rail_c_regs_monitor #(.ADC_WIDTH(ADC_WIDTH)) mon (.*);

// file: verif/i2c_host_model.sv
// Two-wire host that drives clock and data as released-high lines
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int HALF = 4
) (
  // Clock and wire
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wait_half();
    repeat (HALF) @(posedge clk_i);
    #1;
  endtask
  task automatic start();
    sda_o = 1'b1;
    wait_half();
    scl_o = 1'b1;
    wait_half();
    sda_o = 1'b0;
    wait_half();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    sda_o = 1'b0;
    wait_half();
    scl_o = 1'b1;
    wait_half();
    sda_o = 1'b1;
    wait_half();
  endtask
  task automatic clock_bit(input logic b, output logic s);
    sda_o = b;
    wait_half();
    scl_o = 1'b1;
    wait_half();
    s = sda_i;
    scl_o = 1'b0;
  endtask
  // Byte out MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) clock_bit(tx[i], rx[i]);
    clock_bit(ack_in, ack_out);
  endtask
endmodule // i2c_host_model

// file: verif/rail_c_tuning_and_telemetry_regs_bench.sv
// Self-checking bench for the rail C register bank
`timescale 1ns/1ps
module rail_c_tuning_and_telemetry_regs_bench;
  localparam logic [6:0]  DEV = 7'h2a;
  localparam logic [15:0] ID  = 16'hc3a1; // Arbitrary value
  logic         clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         running = 1'b0;
  logic         restore = 1'b0;
  logic [127:0] group = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  logic [29:0]  adc = 30'h0;
  logic [29:0]  report;
  logic [25:0]  fields;
  logic [7:0]   sum;
  logic         scl, host_sda, sda_dut, sda_oe, sda_line;
  int           failures = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  always #25 clk_i = ~clk_i;
  assign sda_line = host_sda & ~(sda_oe & ~sda_dut);
  rail_c_tuning_and_telemetry_regs #(.DEVICE_ADDR(DEV), .CONFIG_ID(ID)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
    .sda_o(sda_dut), .sda_oe_o(sda_oe), .rail_running_i(running),
    .nvm_restore_i(restore), .group_one_i(group), .adc_current_i(adc),
    .current_report_o(report), .transient_target_ratio_o(fields[25:24]),
    .zero_current_level_o(fields[23:18]), .adaptive_ramp_level_o(fields[17:15]),
    .on_time_stretch_enable_o(fields[14]), .on_time_raise_level_o(fields[13:12]),
    .on_time_stretch_select_o(fields[11:10]),
    .ramp_up_compensation_range_o(fields[9:8]),
    .ramp_up_compensation_level_o(fields[7:5]),
    .quick_response_width_o(fields[4:3]), .flat_loadline_enable_o(fields[2]),
    .soft_start_overcurrent_enable_o(fields[1]),
    .amplifier_gain_select_o(fields[0]), .fixed_group_checksum_o(sum));
  i2c_host_model host (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl),
                       .sda_o(host_sda));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  function automatic logic [7:0] crc_exp(input logic [127:0] g,
                                         input logic [7:0] last);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 17; i++) begin
      c ^= (i < 16) ? g[i*8 +: 8] : last;
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
    logic [7:0] rx;
    logic       a;
    host.start();
    host.xfer({DEV, 1'b0}, 1'b1, rx, a);
    check("address ack", 32'h0, a);
    host.xfer(ptr, 1'b1, rx, a);
    foreach (d[i]) host.xfer(d[i], 1'b1, rx, a);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] e[$]);
    logic [7:0] rx;
    logic       a;
    host.start();
    host.xfer({DEV, 1'b0}, 1'b1, rx, a);
    host.xfer(ptr, 1'b1, rx, a);
    host.start();
    host.xfer({DEV, 1'b1}, 1'b1, rx, a);
    foreach (e[i]) begin
      host.xfer(8'hff, i == e.size() - 1, rx, a);
      check("read byte", e[i], rx);
    end
    host.stop();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_map();
    rd(8'h35, '{8'h00, 8'h71, 8'h02, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00,
                8'h00, 8'h00, 8'h00, 8'h00, ID[7:0], ID[15:8],
                crc_exp(group, 8'h00)});
  endtask
  task automatic t_field_codes();
    logic [1:0] v;
    logic [7:0] q[$];
    for (int i = 0; i < 4; i++) begin
      v = 2'(i);
      q = '{{v, v, v, v}, 8'h71, {1'b0, v, v[0], 4'h2}, {3'b0, v[0], v, ~v},
            {2'b0, v, 1'b0, v, v[1]}, {6'b001000, v},
            {v[1], 1'b0, v[0], v[1], 4'h0}};
      wr(8'h35, q);
      check("fields", {v, v, v, v, v, v[0], v[0], v, ~v, v, v, v[1], v,
                       v[1], v[0], v[1]}, fields);
      rd(8'h35, q);
    end
  endtask
  task automatic t_run_lock();
    running = 1'b1;
    wr(8'h3b, '{8'h20});
    check("option while running", 3'b011, fields[2:0]);
    rd(8'h3b, '{8'h30});
    running = 1'b0;
    wr(8'h3b, '{8'h00});
    check("option stopped", 3'b000, fields[2:0]);
  endtask
  task automatic t_telemetry();
    wr(8'h3e, '{8'h7f, 8'hff, 8'h80});
    adc = {10'd100, 10'h3ff, 10'd5};
    @(posedge clk_i);
    #1;
    check("report clamp", {10'd228, 10'h3ff, 10'd0}, report);
    adc = {10'd300, 10'd200, 10'd500};
    @(posedge clk_i);
    #1;
    check("report", {10'd428, 10'd201, 10'd373}, report);
    rd(8'h3e, '{8'h7f, 8'hff, 8'h80});
  endtask
  task automatic t_refused();
    logic [7:0] rx;
    logic       a;
    host.start();
    host.xfer({DEV ^ 7'h01, 1'b0}, 1'b1, rx, a);
    check("foreign address ack", 32'h1, a);
    host.stop();
    wr(8'h41, '{8'h00});
    rd(8'h41, '{ID[7:0]});
    rd(8'h50, '{8'h00});
  endtask
  task automatic t_restore();
    wr(8'h3b, '{8'h10});
    group = ~group;
    restore = 1'b1;
    @(posedge clk_i);
    #1;
    restore = 1'b0;
    repeat (20) @(posedge clk_i);
    #1;
    check("checksum", crc_exp(group, 8'h10), sum);
    rd(8'h43, '{crc_exp(group, 8'h10)});
  endtask
  task automatic finish_test();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset_map();
    t_field_codes();
    t_run_lock();
    t_telemetry();
    t_refused();
    t_restore();
    finish_test();
  end
endmodule // rail_c_tuning_and_telemetry_regs_bench
